// File: core/rmp_pkg.sv
// Package for the range memory protection checker: map, fields, types.
`default_nettype none
package rmp_pkg;
  // ------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ------------------------------------------------------------
  localparam logic [9:0] CTRL_OFS   = 10'h000;
  localparam logic [9:0] STAT_OFS   = 10'h004;
  localparam logic [9:0] IRQ_OFS    = 10'h008;
  localparam logic [9:0] MASK_OFS   = 10'h00C;
  localparam logic [9:0] VADDR_OFS  = 10'h010;
  localparam logic [9:0] DSEL_OFS   = 10'h040;
  localparam logic [9:0] CSEL_OFS   = 10'h050;
  localparam logic [9:0] DPERM_OFS  = 10'h060;
  localparam logic [9:0] CPERM_OFS  = 10'h070;
  localparam logic [9:0] DBND_OFS   = 10'h100;
  localparam logic [9:0] CBND_OFS   = 10'h200;
  // ------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SET_LSB = 4;
  localparam int CTRL_SET_W   = 2;
  localparam int IRQ_R_BIT    = 0;
  localparam int IRQ_W_BIT    = 1;
  localparam int IRQ_X_BIT    = 2;
  localparam int IRQ_W        = 3;
  localparam int BND_LSB      = 3;
  localparam int ADDR_W       = 32;
  localparam int SEG_LSB      = 28;
  localparam logic [3:0] SEG_EMU  = 4'hE;
  localparam logic [3:0] SEG_PERI = 4'hF;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  localparam logic [1:0]  AT_LOAD  = 2'h0;
  localparam logic [1:0]  AT_STORE = 2'h1;
  localparam logic [1:0]  AT_FETCH = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [31:0] addr;
    logic        direct;
    logic        exempt;
  } rmp_req_t;

  typedef struct packed {
    logic permit;
    logic read_violation_trap;
    logic write_violation_trap;
    logic execute_violation_trap;
  } rmp_rsp_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_RD   = 3'b100
  } rmp_bus_st_t;
endpackage
`default_nettype wire

// File: core/rmp_range_hit.sv
// One protection range: boundary compare of an address.
`default_nettype none
module rmp_range_hit (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] lower,
  input  wire logic [31:0] upper,
  output logic             hit
);
  import rmp_pkg::*;
  // Unsigned compare on 8-byte granules only
  assign hit = (addr[ADDR_W-1:BND_LSB] >= lower[ADDR_W-1:BND_LSB]) &&
               (addr[ADDR_W-1:BND_LSB] <  upper[ADDR_W-1:BND_LSB]);
endmodule
`default_nettype wire

// File: core/rmp_checker.sv
// Range memory protection checker with Avalon-MM register slave.
//
// Behaviour
// - Address inside range when lower <= address < upper.
// - Four to sixteen data ranges and four to sixteen code ranges.
// - Boundaries compare only address bits above bit two.
// - Low three boundary bits ignore writes and read zero.
// - Read flag governs loads, write flag stores, execute flag fetches.
// - Each data range pair has read/write flags, each code range pair an execute flag, per set.
// - Two to four protection sets, each a full selection with flags.
// - Checks use the set named by current protection set field.
// - Code and data ranges grouped into pairs.
// - Per set, a select flag per pair picks first or second range.
// - Up to eight select flags per side per set.
// - Grant when any selected containing range permits; OR of permissions.
// - No range protection on peripheral or emulator space.
// - Only direct-translated addresses are checked.
// - Global enable cleared permits every access.
// - Data access outside all selected data ranges is denied.
// - Denied store/load/fetch raises write/read/execute violation trap.
// - Result independent of privilege level.
`default_nettype none
module rmp_checker #(
  parameter int NUM_DRANGE = 16,
  parameter int NUM_CRANGE = 16,
  parameter int NUM_SETS   = 4
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire rmp_pkg::rmp_req_t data_req,
  input  wire rmp_pkg::rmp_req_t fetch_req,
  output rmp_pkg::rmp_rsp_t      data_rsp,
  output rmp_pkg::rmp_rsp_t      fetch_rsp,
  output logic                   irq
);
  import rmp_pkg::*;

  localparam int DPAIRS = NUM_DRANGE / 2;
  localparam int CPAIRS = NUM_CRANGE / 2;

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (NUM_DRANGE < 4 || NUM_DRANGE > 16 || NUM_DRANGE % 2 != 0) begin : g_bad_d
    $error("data range count must be even, 4 to 16");
  end
  if (NUM_CRANGE < 4 || NUM_CRANGE > 16 || NUM_CRANGE % 2 != 0) begin : g_bad_c
    $error("code range count must be even, 4 to 16");
  end
  if (NUM_SETS < 2 || NUM_SETS > 4) begin : g_bad_s
    $error("set count must be 2 to 4");
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [31:0] dlo_r [NUM_DRANGE];
  logic [31:0] dhi_r [NUM_DRANGE];
  logic [31:0] clo_r [NUM_CRANGE];
  logic [31:0] chi_r [NUM_CRANGE];
  logic [7:0]  dsel_r [NUM_SETS];
  logic [7:0]  csel_r [NUM_SETS];
  logic [15:0] dperm_r [NUM_SETS]; // Low byte read, high byte write
  logic [7:0]  cperm_r [NUM_SETS];
  logic        prot_on_r;
  logic [1:0]  cur_set_r;
  logic [IRQ_W-1:0] stat_r, mask_r, stat_nxt;
  logic [31:0] vaddr_r, vaddr_nxt;
  rmp_bus_st_t bus_st_r, bus_st_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // ------------------------------------------------------------
  // Range checks
  // ------------------------------------------------------------
  logic [NUM_DRANGE-1:0] dhit;
  logic [NUM_CRANGE-1:0] chit;

  for (genvar i = 0; i < NUM_DRANGE; i++) begin : g_d
    rmp_range_hit u_hit (
      .addr  (data_req.addr),
      .lower (dlo_r[i]),
      .upper (dhi_r[i]),
      .hit   (dhit[i])
    );
  end
  for (genvar i = 0; i < NUM_CRANGE; i++) begin : g_c
    rmp_range_hit u_hit (
      .addr  (fetch_req.addr),
      .lower (clo_r[i]),
      .upper (chi_r[i]),
      .hit   (chit[i])
    );
  end

  logic rd_ok, wr_ok, x_ok, d_exempt, c_exempt;
  logic d_deny, c_deny;

  // No privilege input exists: the decision cannot depend on it.
  always_comb begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    x_ok  = 1'b0;
    for (int p = 0; p < DPAIRS; p++) begin
      // Selected member of each pair, in the current set
      if (dhit[2*p + int'(dsel_r[cur_set_r][p])]) begin
        rd_ok = rd_ok | dperm_r[cur_set_r][p];
        wr_ok = wr_ok | dperm_r[cur_set_r][8 + p];
      end
    end
    for (int p = 0; p < CPAIRS; p++) begin
      if (chit[2*p + int'(csel_r[cur_set_r][p])]) begin
        x_ok = x_ok | cperm_r[cur_set_r][p];
      end
    end
  end

  function automatic logic seg_exempt(input rmp_req_t r);
    logic [3:0] seg;
    seg = r.addr[ADDR_W-1:SEG_LSB];
    return r.exempt || seg == SEG_PERI || seg == SEG_EMU || !r.direct;
  endfunction

  assign d_exempt = !prot_on_r || seg_exempt(data_req);
  assign c_exempt = !prot_on_r || seg_exempt(fetch_req);

  // Outside all selected ranges leaves every ok low: denied
  assign d_deny = data_req.valid && !d_exempt &&
                  ((data_req.kind == AT_LOAD && !rd_ok) ||
                   (data_req.kind == AT_STORE && !wr_ok));
  assign c_deny = fetch_req.valid && !c_exempt && !x_ok;

  // Combinational so the verdict precedes the memory access
  always_comb begin
    data_rsp.permit                  = !d_deny;
    data_rsp.read_violation_trap     = d_deny && data_req.kind == AT_LOAD;
    data_rsp.write_violation_trap    = d_deny && data_req.kind == AT_STORE;
    data_rsp.execute_violation_trap  = 1'b0;
    fetch_rsp.permit                 = !c_deny;
    fetch_rsp.read_violation_trap    = 1'b0;
    fetch_rsp.write_violation_trap   = 1'b0;
    fetch_rsp.execute_violation_trap = c_deny;
  end

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic        wr_go, rd_go;
  logic [31:0] wmask, wval;
  logic [3:0]  widx;
  logic [1:0]  sidx;

  assign wr_go = avs_write && bus_st_r == BUS_IDLE;
  assign rd_go = avs_read && bus_st_r == BUS_IDLE;
  assign widx  = avs_address[6:3];
  assign sidx  = avs_address[3:2];
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    return (old & ~m) | (d & m);
  endfunction

  // Boundary word: lower at even word, upper at odd, low bits forced zero
  assign wval = merge(32'h0000_0000, wmask, avs_writedata) & ~32'h0000_0007;

  // Bus and interrupt next state
  always_comb begin
    bus_st_nxt = bus_st_r;
    rdata_nxt  = rdata_r;
    stat_nxt   = stat_r;
    vaddr_nxt  = vaddr_r;
    case (bus_st_r)
      BUS_IDLE: begin
        if (avs_write) bus_st_nxt = BUS_ACK;
        else if (avs_read) bus_st_nxt = BUS_RD;
      end
      BUS_RD:   bus_st_nxt = BUS_ACK;
      BUS_ACK:  bus_st_nxt = BUS_IDLE;
      default:  bus_st_nxt = BUS_IDLE;
    endcase
    if (rd_go) begin
      rdata_nxt = UNMAPPED_RD;
      if (avs_address == CTRL_OFS) begin
        rdata_nxt[CTRL_EN_BIT] = prot_on_r;
        rdata_nxt[CTRL_SET_LSB +: CTRL_SET_W] = cur_set_r;
      end else if (avs_address == STAT_OFS) begin
        rdata_nxt[IRQ_W-1:0] = stat_r & mask_r;
      end else if (avs_address == IRQ_OFS) begin
        rdata_nxt[IRQ_W-1:0] = stat_r;
      end else if (avs_address == MASK_OFS) begin
        rdata_nxt[IRQ_W-1:0] = mask_r;
      end else if (avs_address == VADDR_OFS) begin
        rdata_nxt = vaddr_r;
      end else if (avs_address[9:4] == DSEL_OFS[9:4] && int'(sidx) < NUM_SETS) begin
        rdata_nxt[7:0] = dsel_r[sidx];
      end else if (avs_address[9:4] == CSEL_OFS[9:4] && int'(sidx) < NUM_SETS) begin
        rdata_nxt[7:0] = csel_r[sidx];
      end else if (avs_address[9:4] == DPERM_OFS[9:4] && int'(sidx) < NUM_SETS) begin
        rdata_nxt[15:0] = dperm_r[sidx];
      end else if (avs_address[9:4] == CPERM_OFS[9:4] && int'(sidx) < NUM_SETS) begin
        rdata_nxt[7:0] = cperm_r[sidx];
      end else if (avs_address[9:7] == DBND_OFS[9:7] && int'(widx) < NUM_DRANGE) begin
        rdata_nxt = avs_address[2] ? dhi_r[widx] : dlo_r[widx];
      end else if (avs_address[9:7] == CBND_OFS[9:7] && int'(widx) < NUM_CRANGE) begin
        rdata_nxt = avs_address[2] ? chi_r[widx] : clo_r[widx];
      end
    end
    // Write-one clears, but a same-cycle violation wins
    if (wr_go && avs_address == IRQ_OFS && avs_byteenable[0]) begin
      stat_nxt = stat_nxt & ~avs_writedata[IRQ_W-1:0];
    end
    stat_nxt[IRQ_R_BIT] = stat_nxt[IRQ_R_BIT] | data_rsp.read_violation_trap;
    stat_nxt[IRQ_W_BIT] = stat_nxt[IRQ_W_BIT] | data_rsp.write_violation_trap;
    stat_nxt[IRQ_X_BIT] = stat_nxt[IRQ_X_BIT] | fetch_rsp.execute_violation_trap;
    if (d_deny) vaddr_nxt = data_req.addr;
    else if (c_deny) vaddr_nxt = fetch_req.addr;
  end

  assign avs_waitrequest = (avs_read || avs_write) && bus_st_r != BUS_ACK;
  assign avs_readdata    = rdata_r;
  assign irq             = |(stat_r & mask_r);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_st_r <= BUS_IDLE;
      rdata_r  <= 32'h0000_0000;
      stat_r   <= '0;
      vaddr_r  <= 32'h0000_0000;
    end else if (clk_en) begin
      bus_st_r <= bus_st_nxt;
      rdata_r  <= rdata_nxt;
      stat_r   <= stat_nxt;
      vaddr_r  <= vaddr_nxt;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Protection starts off so boot code runs before tables are built
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prot_on_r <= 1'b0;
      cur_set_r <= 2'h0;
      mask_r    <= '0;
      for (int i = 0; i < NUM_DRANGE; i++) begin
        dlo_r[i] <= 32'h0000_0000;
        dhi_r[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < NUM_CRANGE; i++) begin
        clo_r[i] <= 32'h0000_0000;
        chi_r[i] <= 32'h0000_0000;
      end
      for (int s = 0; s < NUM_SETS; s++) begin
        dsel_r[s]  <= 8'h00;
        csel_r[s]  <= 8'h00;
        dperm_r[s] <= 16'h0000;
        cperm_r[s] <= 8'h00;
      end
    end else if (clk_en && wr_go) begin
      if (avs_address == CTRL_OFS && avs_byteenable[0]) begin
        prot_on_r <= avs_writedata[CTRL_EN_BIT];
        // Out-of-range set numbers fold to the last set
        if (int'(avs_writedata[CTRL_SET_LSB +: CTRL_SET_W]) < NUM_SETS)
          cur_set_r <= avs_writedata[CTRL_SET_LSB +: CTRL_SET_W];
        else
          cur_set_r <= 2'(NUM_SETS - 1);
      end
      if (avs_address == MASK_OFS && avs_byteenable[0]) begin
        mask_r <= avs_writedata[IRQ_W-1:0];
      end
      if (int'(sidx) < NUM_SETS) begin
        if (avs_address[9:4] == DSEL_OFS[9:4]) begin
          dsel_r[sidx] <= 8'(merge({24'h0, dsel_r[sidx]}, wmask, avs_writedata))
                          & 8'((1 << DPAIRS) - 1);
        end
        if (avs_address[9:4] == CSEL_OFS[9:4]) begin
          csel_r[sidx] <= 8'(merge({24'h0, csel_r[sidx]}, wmask, avs_writedata))
                          & 8'((1 << CPAIRS) - 1);
        end
        if (avs_address[9:4] == DPERM_OFS[9:4])
          dperm_r[sidx] <= 16'(merge({16'h0, dperm_r[sidx]}, wmask, avs_writedata));
        if (avs_address[9:4] == CPERM_OFS[9:4])
          cperm_r[sidx] <= 8'(merge({24'h0, cperm_r[sidx]}, wmask, avs_writedata));
      end
      if (avs_address[9:7] == DBND_OFS[9:7] && int'(widx) < NUM_DRANGE) begin
        if (avs_address[2]) dhi_r[widx] <= merge(dhi_r[widx], wmask, wval);
        else dlo_r[widx] <= merge(dlo_r[widx], wmask, wval);
      end
      if (avs_address[9:7] == CBND_OFS[9:7] && int'(widx) < NUM_CRANGE) begin
        if (avs_address[2]) chi_r[widx] <= merge(chi_r[widx], wmask, wval);
        else clo_r[widx] <= merge(clo_r[widx], wmask, wval);
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/rmp_checker_chk.sv
// Port-level assertions for the range protection checker.
`default_nettype none
module rmp_checker_chk #(
  parameter int NUM_DRANGE = 16,
  parameter int NUM_CRANGE = 16,
  parameter int NUM_SETS   = 4
) (
  input wire logic              clock,
  input wire logic              nrst,
  input wire logic              clk_en,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  input wire rmp_pkg::rmp_req_t data_req,
  input wire rmp_pkg::rmp_req_t fetch_req,
  input wire rmp_pkg::rmp_rsp_t data_rsp,
  input wire rmp_pkg::rmp_rsp_t fetch_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import rmp_pkg::*;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_nondirect_permit:
    assert property (data_req.valid && !data_req.direct |-> data_rsp.permit)
    else $error("non-direct data access denied");
  a_fetch_nondirect:
    assert property (fetch_req.valid && !fetch_req.direct |-> fetch_rsp.permit)
    else $error("non-direct fetch denied");
  a_segment_exempt:
    assert property (data_req.valid && data_req.addr[31:29] == 3'b111 |-> data_rsp.permit)
    else $error("emulator or peripheral access denied");
  a_load_trap:
    assert property (data_req.valid && data_req.kind == AT_LOAD && !data_rsp.permit
      |-> data_rsp.read_violation_trap && !data_rsp.write_violation_trap)
    else $error("denied load without read trap");
  a_store_trap:
    assert property (data_req.valid && data_req.kind == AT_STORE && !data_rsp.permit
      |-> data_rsp.write_violation_trap && !data_rsp.read_violation_trap)
    else $error("denied store without write trap");
  a_fetch_trap:
    assert property (fetch_req.valid && !fetch_rsp.permit |-> fetch_rsp.execute_violation_trap)
    else $error("denied fetch without execute trap");
  a_grant_clean:
    assert property (data_rsp.permit |-> !data_rsp.read_violation_trap
      && !data_rsp.write_violation_trap && !data_rsp.execute_violation_trap)
    else $error("granted access raised a trap");
  a_grain_stable:
    assert property (data_req.valid && $past(data_req.valid) && !$past(avs_write)
      && data_req.addr[31:3] == $past(data_req.addr[31:3])
      && data_req.kind == $past(data_req.kind) && $stable(data_req.direct)
      && $stable(data_req.exempt) |-> data_rsp.permit == $past(data_rsp.permit))
    else $error("permit changed on low address bits");
  a_write_answer:
    assert property ($rose(avs_write) && clk_en |=> !avs_waitrequest)
    else $error("write not answered after one cycle");
  a_read_answer:
    assert property ($rose(avs_read) && clk_en |=> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after two cycles");
  c_load_deny: cover property (data_req.valid && data_req.kind == AT_LOAD && !data_rsp.permit);
  c_store_ok: cover property (data_req.valid && data_req.kind == AT_STORE && data_rsp.permit);
  c_fetch_deny: cover property (fetch_req.valid && !fetch_rsp.permit);
endmodule
`default_nettype wire

// File: bench/rmp_core_model.sv
// Core-side model: issues load, store and fetch requests.
`default_nettype none
module rmp_core_model (
  input  wire logic         clock,
  output rmp_pkg::rmp_req_t data_req,
  output rmp_pkg::rmp_req_t fetch_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import rmp_pkg::*;
  // ------------------------------------------------------------
  // Request drivers
  // ------------------------------------------------------------
  initial begin
    data_req  = '0;
    fetch_req = '0;
  end
  // Released lines drop valid and invert the other fields; two releases in a row restore those fields, but valid stays low
  function automatic rmp_req_t released(rmp_req_t q);
    return '{1'b0, ~q.kind, ~q.addr, ~q.direct, ~q.exempt};
  endfunction
  task automatic drive(input logic [1:0] kind, input logic [31:0] addr,
                       input logic direct, input logic exempt);
    @(posedge clock);
    if (kind == AT_FETCH) begin
      fetch_req <= '{1'b1, kind, addr, direct, exempt};
      data_req  <= released(data_req);
    end else begin
      data_req  <= '{1'b1, kind, addr, direct, exempt};
      fetch_req <= released(fetch_req);
    end
  endtask
  task automatic idle();
    @(posedge clock);
    data_req  <= released(data_req);
    fetch_req <= released(fetch_req);
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench: register setup over Avalon, then access checks.
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rmp_pkg::*;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [9:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [31:0] rd;
  rmp_req_t    data_req;
  rmp_req_t    fetch_req;
  rmp_rsp_t    data_rsp;
  rmp_rsp_t    fetch_rsp;
  int          failures = 0;
  int          comparisons = 0;
  always #4 clock = ~clock;
  rmp_checker dut (.clock(clock), .nrst(nrst), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .data_req(data_req), .fetch_req(fetch_req), .data_rsp(data_rsp),
    .fetch_rsp(fetch_rsp), .irq(irq));
  rmp_core_model core (.clock(clock), .data_req(data_req), .fetch_req(fetch_req));
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Request held until waitrequest is seen low at a rising edge; a hang is the watchdog's
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !is_wr;
    avs_write     <= is_wr;
    do @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask
  task automatic rng(input logic code, input int i, input logic [31:0] lo, hi);
    wr((code ? CBND_OFS : DBND_OFS) + 10'(8 * i), lo);
    wr((code ? CBND_OFS : DBND_OFS) + 10'(8 * i + 4), hi);
  endtask
  task automatic acc(input logic [1:0] k, input logic [31:0] a, input logic dir, ok);
    rmp_rsp_t e;
    core.drive(k, a, dir, 1'b0);
    e = '{ok, !ok && k == AT_LOAD, !ok && k == AT_STORE, !ok && k == AT_FETCH};
    @(negedge clock);
    if (k == AT_FETCH) `CHK("fetch_rsp", e, fetch_rsp)
    else `CHK("data_rsp", e, data_rsp)
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rdchk("ctrl", CTRL_OFS, 32'h0000_0000);
    acc(AT_STORE, 32'h0000_1000, 1'b1, 1'b1);
    rng(1'b0, 0, 32'h1000_0007, 32'h1000_0105);
    rdchk("lower", DBND_OFS, 32'h1000_0000);
    rdchk("upper", DBND_OFS + 10'h004, 32'h1000_0100);
    rng(1'b0, 1, 32'h3000_0000, 32'h3000_0100);
    rng(1'b0, 2, 32'h1000_0080, 32'h1000_0200);
    rng(1'b1, 0, 32'h2000_0000, 32'h2000_0040);
    wr(DPERM_OFS, 32'h0000_0201);
    wr(CPERM_OFS, 32'h0000_0001);
    wr(CTRL_OFS, 32'h0000_0001);
    acc(AT_LOAD, 32'h1000_0000, 1'b1, 1'b1);
    acc(AT_LOAD, 32'h0FFF_FFFF, 1'b1, 1'b0);
    acc(AT_LOAD, 32'h1000_00F8, 1'b1, 1'b1);
    acc(AT_LOAD, 32'h1000_00FF, 1'b1, 1'b1);
    acc(AT_LOAD, 32'h1000_0100, 1'b1, 1'b0);
    acc(AT_STORE, 32'h1000_0010, 1'b1, 1'b0);
    acc(AT_STORE, 32'h1000_0090, 1'b1, 1'b1);
    acc(AT_LOAD, 32'h1000_0180, 1'b1, 1'b0);
    acc(AT_LOAD, 32'hE000_0000, 1'b1, 1'b1);
    acc(AT_STORE, 32'hF000_0000, 1'b1, 1'b1);
    acc(AT_LOAD, 32'h0000_0000, 1'b0, 1'b1);
    acc(AT_FETCH, 32'h2000_003C, 1'b1, 1'b1);
    acc(AT_FETCH, 32'h2000_0040, 1'b1, 1'b0);
    wr(DSEL_OFS, 32'h0000_0001);
    acc(AT_LOAD, 32'h3000_0000, 1'b1, 1'b1);
    acc(AT_LOAD, 32'h1000_0000, 1'b1, 1'b0);
    wr(CTRL_OFS, 32'h0000_0011);
    acc(AT_LOAD, 32'h3000_0000, 1'b1, 1'b0);
    acc(AT_FETCH, 32'h2000_0000, 1'b1, 1'b0);
    wr(CTRL_OFS, 32'h0000_0010);
    acc(AT_FETCH, 32'h2000_0040, 1'b1, 1'b1);
    core.idle();
    `CHK("irq", 1'b0, irq)
    wr(MASK_OFS, 32'h0000_0007);
    `CHK("irq", 1'b1, irq)
    rdchk("status", IRQ_OFS, 32'h0000_0007);
    rdchk("masked", STAT_OFS, 32'h0000_0007);
    wr(IRQ_OFS, 32'h0000_0002);
    rdchk("status", IRQ_OFS, 32'h0000_0005);
    wr(IRQ_OFS, 32'h0000_0005);
    `CHK("irq", 1'b0, irq)
    wr(CTRL_OFS, 32'h0000_0001);
    core.drive(AT_STORE, 32'h0FFF_FFF8, 1'b1, 1'b1);
    @(negedge clock);
    `CHK("exempt", 4'h8, data_rsp)
    acc(AT_LOAD, 32'h0FFF_FFF8, 1'b1, 1'b0);
    core.idle();
    rdchk("vaddr", VADDR_OFS, 32'h0FFF_FFF8);
    rdchk("status", IRQ_OFS, 32'h0000_0001);
    rdchk("unmapped", 10'h3FC, UNMAPPED_RD);
    complete_run();
  end
endmodule
bind rmp_checker rmp_checker_chk #(.NUM_DRANGE(NUM_DRANGE), .NUM_CRANGE(NUM_CRANGE),
  .NUM_SETS(NUM_SETS)) u_chk (.clock(clock), .nrst(nrst), .clk_en(clk_en),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .data_req(data_req), .fetch_req(fetch_req), .data_rsp(data_rsp), .fetch_rsp(fetch_rsp));
`default_nettype wire
